/* File: inc/rcr_pkg.sv */
// package of constants and types for the reset cause recorder
package rcr_pkg;

    localparam int RCR_NFLAGS = 9;
    localparam int RCR_AW     = 8;
    localparam int RCR_DW     = 32;

    // register byte offsets
    localparam logic [RCR_AW-1:0] RCR_OFS_FLAGS = 8'h00;
    localparam logic [RCR_AW-1:0] RCR_OFS_CMD   = 8'h08;
    localparam logic [RCR_AW-1:0] RCR_OFS_HCMD  = 8'h0C;
    localparam logic [RCR_AW-1:0] RCR_OFS_ISTAT = 8'h10;
    localparam logic [RCR_AW-1:0] RCR_OFS_IMASK = 8'h14;

    // field positions
    localparam int RCR_BIT_PWRUP     = 0;
    localparam int RCR_BIT_STALL     = 5;
    localparam int RCR_CMD_CLR_BIT   = 0;
    localparam int RCR_HCMD_CLR_BIT  = 0;

    // flags that the ordinary clear command leaves alone
    localparam logic [RCR_NFLAGS-1:0] RCR_SOFT_KEEP =
        9'(1 << RCR_BIT_STALL) | 9'(1 << RCR_BIT_PWRUP);

    // reset values
    localparam logic [RCR_NFLAGS-1:0] RCR_FLAGS_RST = 9'h000;
    localparam logic [RCR_NFLAGS-1:0] RCR_IRQ_RST   = 9'h000;
    localparam logic [RCR_DW-1:0]     RCR_RDATA_RST = 32'h0000_0000;

    // one bit per cause, bit 8 down to bit 0
    typedef struct packed {
        logic deep_sleep_pin_wake_flag;
        logic deep_sleep_entry_flag;
        logic software_request_reset_flag;
        logic core_stall_reset_flag;
        logic watchdog_reset_flag;
        logic pin_reset_flag;
        logic core_supply_droop_flag;
        logic main_supply_droop_flag;
        logic power_up_reset_flag;
    } rcr_cause_t;

    typedef struct packed {
        logic [RCR_AW-1:0] addr;
        logic [RCR_DW-1:0] wdata;
        logic              wr;
        logic              rd;
    } rcr_bus_req_t;

    typedef struct packed {
        logic flag;
    } rcr_flag_st_t;

    typedef struct packed {
        logic [RCR_NFLAGS-1:0] status;
        logic [RCR_NFLAGS-1:0] mask;
    } rcr_irq_st_t;

    typedef struct packed {
        logic [RCR_DW-1:0] rdata;
    } rcr_top_st_t;

endpackage

/* File: src/rcr_flag.sv */
// one sticky reset cause flag
`timescale 1ns/1ns
`default_nettype none
module rcr_flag (
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);
    import rcr_pkg::*;

    rcr_flag_st_t st_q;
    rcr_flag_st_t st_d;

    // set beats a clear in the same cycle so no cause is lost
    always_comb begin
        st_d = st_q;
        if (set_i) begin
            st_d.flag = 1'b1;
        end else if (clr_i) begin
            st_d.flag = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag_o = st_q.flag;

endmodule
`default_nettype wire

/* File: src/rcr_irq.sv */
// sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ns
`default_nettype none
module rcr_irq (
    input  wire logic                          sys_clk_i,
    input  wire logic                          resetn_i,
    input  wire logic [rcr_pkg::RCR_NFLAGS-1:0] evt_i,
    input  wire logic                          wr_status_i,
    input  wire logic                          wr_mask_i,
    input  wire logic [rcr_pkg::RCR_NFLAGS-1:0] wdata_i,
    output logic      [rcr_pkg::RCR_NFLAGS-1:0] status_o,
    output logic      [rcr_pkg::RCR_NFLAGS-1:0] mask_o,
    output logic                               irq_o
);
    import rcr_pkg::*;

    rcr_irq_st_t st_q;
    rcr_irq_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (wr_status_i) begin
            st_d.status = st_q.status & ~wdata_i;
        end
        // events land after the clear, so they win
        st_d.status = st_d.status | evt_i;
        if (wr_mask_i) begin
            st_d.mask = wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q.status <= RCR_IRQ_RST;
            st_q.mask   <= RCR_IRQ_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign status_o = st_q.status;
    assign mask_o   = st_q.mask;
    assign irq_o    = |(st_q.status & st_q.mask);

endmodule
`default_nettype wire

/* File: src/rcr_top.sv */
// reset cause recorder: sticky cause flags, clear commands, interrupt
//
// Overview of operation
// - bit 7 is set once the system has been in the deepest energy mode and is 0 after reset.
// - bit 6 is set when a software system-request reset was carried out.
// - bit 5 is set when a core lockup reset was requested.
// - bit 4 is set when a watchdog reset was performed.
// - bit 3 is set when the chip was reset through its external pin.
// - bit 2 is set when the core supply brown-out detector forced a reset.
// - bit 1 is set when the main supply brown-out detector forced a reset.
// - bit 0 is set when a power-on reset occurred.
// - the flags are sticky and read-only, held until software clears them or resetn_i is asserted.
// - writing 1 to bit 0 at offset 0x008 clears all flags but lockup and power-on, which a separate hard clear handles.
// - bit 8 is set when a pin woke the chip from the deepest energy mode.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module rcr_top (
    input  wire logic                   sys_clk_i,
    input  wire logic                   resetn_i,
    input  wire rcr_pkg::rcr_cause_t    cause_i,
    input  wire rcr_pkg::rcr_bus_req_t  bus_req_i,
    output logic [rcr_pkg::RCR_DW-1:0]  bus_rdata_o,
    output rcr_pkg::rcr_cause_t         flags_o,
    output logic                        irq_o
);
    import rcr_pkg::*;

    rcr_top_st_t st_q;
    rcr_top_st_t st_d;

    logic [RCR_NFLAGS-1:0] cause_v;
    logic [RCR_NFLAGS-1:0] flags_v;
    logic [RCR_NFLAGS-1:0] clr_v;
    logic [RCR_NFLAGS-1:0] irq_status;
    logic [RCR_NFLAGS-1:0] irq_mask;
    logic [RCR_NFLAGS-1:0] new_set;
    logic                  wr_cmd;
    logic                  wr_hcmd;
    logic                  wr_istat;
    logic                  wr_imask;
    logic                  soft_clr;
    logic                  hard_clr;

    assign cause_v = cause_i;

    // register write decode
    always_comb begin
        wr_cmd   = 1'b0;
        wr_hcmd  = 1'b0;
        wr_istat = 1'b0;
        wr_imask = 1'b0;
        if (!bus_req_i.wr) begin
            wr_cmd = 1'b0;
        end else if (bus_req_i.addr == RCR_OFS_CMD) begin
            wr_cmd = 1'b1;
        end else if (bus_req_i.addr == RCR_OFS_HCMD) begin
            wr_hcmd = 1'b1;
        end else if (bus_req_i.addr == RCR_OFS_ISTAT) begin
            wr_istat = 1'b1;
        end else if (bus_req_i.addr == RCR_OFS_IMASK) begin
            wr_imask = 1'b1;
        end
    end

    // clear commands exist only in the write cycle; upper bits ignored
    assign soft_clr = wr_cmd & bus_req_i.wdata[RCR_CMD_CLR_BIT];
    assign hard_clr = wr_hcmd & bus_req_i.wdata[RCR_HCMD_CLR_BIT];

    // ordinary clear spares the kept flags, hard clear takes all
    assign clr_v = ({RCR_NFLAGS{soft_clr}} & ~RCR_SOFT_KEEP)
                 | {RCR_NFLAGS{hard_clr}};

    // flags sit on the same resetn_i as the rest, so every reset clears them
    for (genvar i = 0; i < RCR_NFLAGS; i++) begin : g_flag
        rcr_flag u_flag (
            .sys_clk_i (sys_clk_i),
            .resetn_i  (resetn_i),
            .set_i     (cause_v[i]),
            .clr_i     (clr_v[i]),
            .flag_o    (flags_v[i])
        );
    end

    assign flags_o = flags_v;

    // interrupt only on a fresh cause, not on repeats of a held flag
    assign new_set = cause_v & ~flags_v;

    rcr_irq u_irq (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (resetn_i),
        .evt_i       (new_set),
        .wr_status_i (wr_istat),
        .wr_mask_i   (wr_imask),
        .wdata_i     (bus_req_i.wdata[RCR_NFLAGS-1:0]),
        .status_o    (irq_status),
        .mask_o      (irq_mask),
        .irq_o       (irq_o)
    );

    // read data stand only in the cycle after the strobe
    always_comb begin
        st_d       = st_q;
        st_d.rdata = RCR_RDATA_RST;
        if (!bus_req_i.rd) begin
            st_d.rdata = RCR_RDATA_RST;
        end else if (bus_req_i.addr == RCR_OFS_FLAGS) begin
            st_d.rdata = {{(RCR_DW-RCR_NFLAGS){1'b0}}, flags_v};
        end else if (bus_req_i.addr == RCR_OFS_ISTAT) begin
            st_d.rdata = {{(RCR_DW-RCR_NFLAGS){1'b0}}, irq_status};
        end else if (bus_req_i.addr == RCR_OFS_IMASK) begin
            st_d.rdata = {{(RCR_DW-RCR_NFLAGS){1'b0}}, irq_mask};
        end
        // command registers are write-only and read as zero
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q.rdata <= RCR_RDATA_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus_rdata_o = st_q.rdata;

    // checks

    default clocking cb @(posedge sys_clk_i);
    endclocking

    default disable iff (!resetn_i);

    sequence cmd_read_s;
        bus_req_i.rd && (bus_req_i.addr == RCR_OFS_CMD);
    endsequence

    sequence cmd_zero_write_s;
        wr_cmd && !bus_req_i.wdata[RCR_CMD_CLR_BIT] && !hard_clr;
    endsequence

    sequence flags_read_s;
        bus_req_i.rd && (bus_req_i.addr == RCR_OFS_FLAGS);
    endsequence

    deep_entry_set_a: assert property (
        cause_i.deep_sleep_entry_flag |=> flags_o.deep_sleep_entry_flag)
        else $error("deep sleep entry flag not set");

    sw_req_set_a: assert property (
        cause_i.software_request_reset_flag
        |=> flags_o.software_request_reset_flag)
        else $error("software request flag not set");

    stall_set_a: assert property (
        cause_i.core_stall_reset_flag |=> flags_o.core_stall_reset_flag)
        else $error("core stall flag not set");

    wdog_set_a: assert property (
        cause_i.watchdog_reset_flag |=> flags_o.watchdog_reset_flag)
        else $error("watchdog flag not set");

    pin_set_a: assert property (
        cause_i.pin_reset_flag |=> flags_o.pin_reset_flag)
        else $error("pin reset flag not set");

    core_droop_set_a: assert property (
        cause_i.core_supply_droop_flag |=> flags_o.core_supply_droop_flag)
        else $error("core supply droop flag not set");

    main_droop_set_a: assert property (
        cause_i.main_supply_droop_flag |=> flags_o.main_supply_droop_flag)
        else $error("main supply droop flag not set");

    power_up_set_a: assert property (
        cause_i.power_up_reset_flag |=> flags_o.power_up_reset_flag)
        else $error("power-up flag not set");

    pin_wake_set_a: assert property (
        cause_i.deep_sleep_pin_wake_flag
        |=> flags_o.deep_sleep_pin_wake_flag)
        else $error("pin wake flag not set");

    flags_sticky_a: assert property (
        !soft_clr && !hard_clr
        |=> (flags_v & $past(flags_v)) == $past(flags_v))
        else $error("flag dropped without a clear");

    flags_readback_a: assert property (
        flags_read_s
        |=> bus_rdata_o[RCR_NFLAGS-1:0] == $past(flags_v))
        else $error("flag read data wrong");

    soft_clear_a: assert property (
        soft_clr && !hard_clr
        |=> (flags_v & ~RCR_SOFT_KEEP & ~$past(cause_v)) == '0)
        else $error("soft clear left a flag set");

    stall_kept_a: assert property (
        soft_clr && !hard_clr && flags_o.core_stall_reset_flag
        |=> flags_o.core_stall_reset_flag)
        else $error("soft clear removed the lockup flag");

    hard_clear_a: assert property (
        hard_clr |=> (flags_v & ~$past(cause_v)) == '0)
        else $error("hard clear left a flag set");

    cmd_reads_zero_a: assert property (
        cmd_read_s |=> bus_rdata_o == '0)
        else $error("command register read nonzero");

    zero_write_idle_a: assert property (
        cmd_zero_write_s
        |=> flags_v == ($past(flags_v) | $past(cause_v)))
        else $error("zero write to command changed flags");

    rdata_one_cycle_a: assert property (
        !bus_req_i.rd |=> bus_rdata_o == '0)
        else $error("read data outside answer cycle");

endmodule
`default_nettype wire

/* File: sim/rcr_tb.sv */
// self-checking testbench for the reset cause recorder
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import rcr_pkg::*;

    logic              sys_clk_i = 1'b0;
    logic              resetn_i  = 1'b1;
    rcr_cause_t        cause_i   = '0;
    rcr_bus_req_t      bus_req_i = '0;
    logic [RCR_DW-1:0] bus_rdata_o;
    rcr_cause_t        flags_o;
    logic              irq_o;
    logic [8:0]        m_flags   = '0;
    logic [8:0]        m_stat    = '0;
    logic [8:0]        m_mask    = '0;
    logic [RCR_DW-1:0] exp_q[$];
    logic              rd_seen   = 1'b0;
    logic [7:0]        addr_tab[6] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h04};
    int                bad_count  = 0;
    int                num_checks = 0;
    int                seed       = 89;
    int                k;
    logic [7:0]        ra;
    logic [31:0]       rd_v;

    rcr_top dut (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (resetn_i),
        .cause_i     (cause_i),
        .bus_req_i   (bus_req_i),
        .bus_rdata_o (bus_rdata_o),
        .flags_o     (flags_o),
        .irq_o       (irq_o)
    );

    always #20 sys_clk_i = ~sys_clk_i;

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (e !== g) begin
            bad_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // one bus cycle plus cause inputs; model moves as the dut will
    task automatic op(input logic w, input logic r, input logic [7:0] a,
                      input logic [31:0] d, input logic [8:0] c);
        logic [8:0] clr;
        @(posedge sys_clk_i);
        bus_req_i <= '{addr: a, wdata: d, wr: w, rd: r};
        cause_i   <= c;
        #1;
        chk({23'h0, m_flags}, {23'h0, flags_o});
        chk({31'h0, |(m_stat & m_mask)}, {31'h0, irq_o});
        if (r)
            exp_q.push_back(a == RCR_OFS_FLAGS ? {23'h0, m_flags} :
                            a == RCR_OFS_ISTAT ? {23'h0, m_stat}  :
                            a == RCR_OFS_IMASK ? {23'h0, m_mask}  : 32'h0);
        clr = '0;
        if (w && d[0] && a == RCR_OFS_CMD) clr = ~RCR_SOFT_KEEP;
        if (w && d[0] && a == RCR_OFS_HCMD) clr = 9'h1FF;
        // set wins over a clear in the same cycle
        m_stat = (m_stat & ~((w && a == RCR_OFS_ISTAT) ? d[8:0] : 9'h000))
                 | (c & ~m_flags);
        if (w && a == RCR_OFS_IMASK) m_mask = d[8:0];
        m_flags = (m_flags & ~clr) | c;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        op(1'b1, 1'b0, a, d, 9'h000);
    endtask

    task automatic rd(input logic [7:0] a);
        op(1'b0, 1'b1, a, 32'h0, 9'h000);
    endtask

    task automatic ev(input logic [8:0] c);
        op(1'b0, 1'b0, 8'h00, 32'h0, c);
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge sys_clk_i) begin
        if (rd_seen)
            chk(exp_q.size() ? exp_q.pop_front() : 32'hFFFF_FFFF, bus_rdata_o);
        else
            chk(32'h0, bus_rdata_o);
        rd_seen <= bus_req_i.rd;
    end

    initial begin
        #200000;
        bad_count++;
        end_sim();
    end

    initial begin
        // a real falling edge, so the asynchronous clears act before any check
        resetn_i <= 1'b0;
        repeat (12) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        rd(RCR_OFS_FLAGS);
        rd(RCR_OFS_ISTAT);
        rd(RCR_OFS_IMASK);
        rd(RCR_OFS_CMD);
        rd(RCR_OFS_HCMD);
        rd(8'h04);
        wr(RCR_OFS_IMASK, 32'h0000_01FF);
        for (int i = 0; i < 9; i++) begin
            ev(9'(1 << i));
            rd(RCR_OFS_FLAGS);
        end
        ev(9'h1FF);
        wr(RCR_OFS_CMD, 32'h0000_0000);
        rd(RCR_OFS_FLAGS);
        repeat (3) ev(9'h000);
        wr(RCR_OFS_CMD, 32'h0000_0001);
        rd(RCR_OFS_FLAGS);
        wr(RCR_OFS_HCMD, 32'h0000_0001);
        rd(RCR_OFS_FLAGS);
        ev(9'h010);
        op(1'b1, 1'b0, RCR_OFS_CMD, 32'h1, 9'h010);
        rd(RCR_OFS_FLAGS);
        wr(RCR_OFS_ISTAT, 32'h0000_01FF);
        ev(9'h010);
        rd(RCR_OFS_ISTAT);
        wr(RCR_OFS_IMASK, 32'h0000_0000);
        ev(9'h008);
        rd(RCR_OFS_ISTAT);
        repeat (300) begin
            k    = $unsigned($random(seed)) % 3;
            ra   = addr_tab[$unsigned($random(seed)) % 6];
            rd_v = $random(seed);
            // command words keep their upper bits zero
            if (ra == RCR_OFS_CMD || ra == RCR_OFS_HCMD) rd_v &= 32'h1;
            op(k == 0, k == 1, ra, rd_v,
               9'($random(seed) & $random(seed) & $random(seed)));
        end
        repeat (2) ev(9'h000);
        @(posedge sys_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        m_flags = '0;
        m_stat  = '0;
        m_mask  = '0;
        resetn_i <= 1'b1;
        rd(RCR_OFS_FLAGS);
        repeat (2) ev(9'h000);
        end_sim();
    end
endmodule
`default_nettype wire
